// [common/srmc_pkg.sv]
// Purpose: Constants for the switch reset and mode control block
// Assumes: 250 MHz reference clock, word-aligned register port
// Notes:   Strap codes, register map and status fields live here

package srmc_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 250;
    localparam int SMB_HALF_NS  = 5000;
    localparam int SMB_HALF_INT = (SMB_HALF_NS * CLK_MHZ) / 1000;
    localparam int SMB_CNT_W    = 11;
    localparam logic [SMB_CNT_W-1:0] SMB_HALF_CYC = SMB_CNT_W'(SMB_HALF_INT);

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_SWITCH_CONTROL_REGISTER_ADDR  = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS_ADDR = 8'h04;
    localparam int SWITCH_CONTROL_REGISTER_HALT_BIT = 0;

    // Status word fields
    localparam int ST_STATE_LSB = 0;
    localparam int ST_NORMAL    = 2;
    localparam int ST_QUASI     = 3;
    localparam int ST_STRAP_LSB = 4;
    localparam int ST_FSEL      = 8;
    localparam int ST_CLKM_LSB  = 9;
    localparam int ST_MODE_LSB  = 16;

    // ------------------------------------------------------------
    // Straps
    // ------------------------------------------------------------
    localparam int STRAP_W = 4;
    localparam int CLKM_W  = 2;
    localparam int PIN_W   = 2 + STRAP_W + 1 + CLKM_W;

    localparam logic [STRAP_W-1:0] SW_SINGLE       = 4'h0;
    localparam logic [STRAP_W-1:0] SW_SINGLE_EE    = 4'h1;
    localparam logic [STRAP_W-1:0] SW_SINGLE_J0    = 4'h2;
    localparam logic [STRAP_W-1:0] SW_SINGLE_J1    = 4'h3;
    localparam logic [STRAP_W-1:0] SW_RSVD_LO      = 4'h4;
    localparam logic [STRAP_W-1:0] SW_RSVD_HI      = 4'h7;
    localparam logic [STRAP_W-1:0] SW_LOWLAT       = 4'h8;
    localparam logic [STRAP_W-1:0] SW_LOWLAT_EE    = 4'h9;
    localparam logic [STRAP_W-1:0] SW_MULTI_UA     = 4'hA;
    localparam logic [STRAP_W-1:0] SW_MULTI_UA_I2C = 4'hB;
    localparam logic [STRAP_W-1:0] SW_MULTI_UA_EE  = 4'hC;
    localparam logic [STRAP_W-1:0] SW_MULTI_UA_ALL = 4'hD;
    localparam logic [STRAP_W-1:0] SW_MULTI_DIS_A  = 4'hE;
    localparam logic [STRAP_W-1:0] SW_MULTI_DIS_B  = 4'hF;

    // Reference clock select
    localparam logic       FSEL_100 = 1'b0;
    localparam logic [7:0] MHZ_100  = 8'h64;
    localparam logic [7:0] MHZ_125  = 8'h7D;

    // EEPROM load kinds
    localparam logic [1:0] EE_NONE  = 2'h0;
    localparam logic [1:0] EE_PLAIN = 2'h1;
    localparam logic [1:0] EE_JUMP0 = 2'h2;
    localparam logic [1:0] EE_JUMP1 = 2'h3;

    // Decoded mode vector
    localparam int MD_EE_LSB = 0;
    localparam int MD_MULTI  = 2;
    localparam int MD_LAT    = 3;
    localparam int MD_I2C    = 4;
    localparam int MD_DIS    = 5;
    localparam int MD_RSVD   = 6;
    localparam int MD_W      = 7;

    typedef enum logic [1:0] {
        S_IN_RESET,
        S_EEPROM_INIT,
        S_QUASI_RESET,
        S_NORMAL
    } srmc_state_type;

endpackage

// [src/srmc_sync.sv]
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous to REF clock
// Notes:   Output moves only when stages two and three agree

`timescale 1ns/1ns

module srmc_sync #(
    parameter int WIDTH = 1
) (
    // Clock, reset, enable
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    // Data
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // ------------------------------------------------------------
    // Shift chain; stage1 feeds only stage2
    // ------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end
        else if (ce_in)
        begin
            stage1 <= d_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // ------------------------------------------------------------
    // Accept a new value only once it has stood two samples
    // ------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            q_out <= '0;
        else if (ce_in && (stage2 == stage3))
            q_out <= stage3;
    end

endmodule

// [src/srmc_top.sv]
// Purpose: Fundamental reset, halt-after-reset and strap decode
// Assumes: Straps static after reset release; one 250 MHz clock
// Notes:   Master serial clock is open drain, driven low only
//
// Behaviour
// [RULE1] Fundamental reset holds all logic in reset; captured straps and decoded mode outputs keep their values through it
// [RULE2] Halt strap during reset leaves device quasi-reset
// [RULE3] Quasi-reset accepts register access, no switching
// [RULE4] Clearing halt bit starts normal operation
// [RULE5] Frequency select 0 is 100, 1 is 125 MHz
// [RULE6] Board keeps mode straps static after reset
// [RULE7] Codes 0 to 3 single partition, EEPROM variants
// [RULE8] Codes 4 to 7 reserved, board avoids them
// [RULE9] Codes 8,9 reduced latency, 9 adds EEPROM
// [RULE10] Codes A to D multi-partition, unattached ports
// [RULE11] Codes E,F multi-partition, unassigned ports disabled
// [RULE12] Port clocking mode taken from two select pins
// [RULE13] Master serial clock runs only during accesses
// [RULE14] Straps captured at reset release, held until reset
// [RULE15] Without halt, go to EEPROM load or normal
//
// Added by the designer: strobed register access and the address map.

`timescale 1ns/1ns

module srmc_top (
    // Clock, reset, enable
    input  wire logic                          REF_CLK_IN,
    input  wire logic                          RST_IN,
    input  wire logic                          CE_IN,
    // Board pins
    input  wire logic                          FUNDAMENTAL_RESET_N_IN,
    input  wire logic                          HALT_AFTER_RESET_IN,
    input  wire logic [srmc_pkg::STRAP_W-1:0]  SWITCH_CONFIG_STRAP_IN,
    input  wire logic                          REFCLK_FREQ_SELECT_IN,
    input  wire logic [srmc_pkg::CLKM_W-1:0]   PORT_CLOCKING_SELECT_IN,
    // Master serial clock pin
    input  wire logic                          MGMT_MASTER_SERIAL_CLOCK_IN,
    output logic                               MGMT_MASTER_SERIAL_CLOCK_OUT,
    output logic                               MGMT_MASTER_SERIAL_CLOCK_OE_OUT,
    // EEPROM loader and expander access
    input  wire logic                          EEPROM_DONE_IN,
    input  wire logic                          IOEXP_ACCESS_IN,
    // Register port
    input  wire logic [srmc_pkg::ADDR_W-1:0]   ADDR_IN,
    input  wire logic [srmc_pkg::DATA_W-1:0]   WDATA_IN,
    input  wire logic                          WR_IN,
    input  wire logic                          RD_IN,
    output logic      [srmc_pkg::DATA_W-1:0]   RDATA_OUT,
    // Operating state
    output logic                               INTERNAL_RESET_OUT,
    output logic                               EEPROM_INIT_OUT,
    output logic                               QUASI_RESET_OUT,
    output logic                               NORMAL_OP_OUT,
    // Decoded configuration
    output logic [1:0]                         EEPROM_KIND_OUT,
    output logic                               MULTI_PARTITION_OUT,
    output logic                               REDUCED_LATENCY_OUT,
    output logic                               I2C_RESET_OUT,
    output logic                               PORTS_DISABLED_OUT,
    output logic                               STRAP_RESERVED_OUT,
    output logic [7:0]                         REFCLK_MHZ_OUT,
    output logic [srmc_pkg::CLKM_W-1:0]        PORT_CLOCK_MODE_OUT
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [srmc_pkg::PIN_W-1:0]     pins_sync;
    logic                           fund_n_s;
    logic                           halt_s;
    logic [srmc_pkg::STRAP_W-1:0]   strap_s;
    logic                           fsel_s;
    logic [srmc_pkg::CLKM_W-1:0]    clkm_s;
    logic                           smb_clk_s;
    logic                           in_reset;
    logic                           release_now;

    srmc_pkg::srmc_state_type       state;
    srmc_pkg::srmc_state_type       next_state;

    logic                           halt_latched;
    logic                           halt_bit;
    logic [srmc_pkg::STRAP_W-1:0]   strap_cap;
    logic                           fsel_cap;
    logic [srmc_pkg::CLKM_W-1:0]    clkm_cap;
    logic [srmc_pkg::MD_W-1:0]      mode_cap;
    logic [srmc_pkg::MD_W-1:0]      live_mode;

    logic                           smb_active;
    logic [srmc_pkg::SMB_CNT_W-1:0] smb_cnt;
    logic                           smb_low;
    logic [srmc_pkg::DATA_W-1:0]    read_mux;
    logic                           wr_switch_control_register;

    // ------------------------------------------------------------
    // Strap decode
    // ------------------------------------------------------------
    function automatic logic [srmc_pkg::MD_W-1:0] decode_mode(
        input logic [srmc_pkg::STRAP_W-1:0] code
    );
        logic [srmc_pkg::MD_W-1:0] m;
        m = '0;
        case (code)
            srmc_pkg::SW_SINGLE:
                m[srmc_pkg::MD_EE_LSB +: 2] = srmc_pkg::EE_NONE; // RULE7
            srmc_pkg::SW_SINGLE_EE:
                m[srmc_pkg::MD_EE_LSB +: 2] = srmc_pkg::EE_PLAIN; // RULE7
            srmc_pkg::SW_SINGLE_J0:
                m[srmc_pkg::MD_EE_LSB +: 2] = srmc_pkg::EE_JUMP0; // RULE7
            srmc_pkg::SW_SINGLE_J1:
                m[srmc_pkg::MD_EE_LSB +: 2] = srmc_pkg::EE_JUMP1; // RULE7
            srmc_pkg::SW_LOWLAT:
                m[srmc_pkg::MD_LAT] = 1'b1; // RULE9
            srmc_pkg::SW_LOWLAT_EE:
            begin
                m[srmc_pkg::MD_LAT]         = 1'b1; // RULE9
                m[srmc_pkg::MD_EE_LSB +: 2] = srmc_pkg::EE_PLAIN;
            end
            srmc_pkg::SW_MULTI_UA:
                m[srmc_pkg::MD_MULTI] = 1'b1; // RULE10
            srmc_pkg::SW_MULTI_UA_I2C:
            begin
                m[srmc_pkg::MD_MULTI] = 1'b1; // RULE10
                m[srmc_pkg::MD_I2C]   = 1'b1;
            end
            srmc_pkg::SW_MULTI_UA_EE:
            begin
                m[srmc_pkg::MD_MULTI]       = 1'b1; // RULE10
                m[srmc_pkg::MD_EE_LSB +: 2] = srmc_pkg::EE_PLAIN;
            end
            srmc_pkg::SW_MULTI_UA_ALL:
            begin
                m[srmc_pkg::MD_MULTI]       = 1'b1; // RULE10
                m[srmc_pkg::MD_I2C]         = 1'b1;
                m[srmc_pkg::MD_EE_LSB +: 2] = srmc_pkg::EE_PLAIN;
            end
            srmc_pkg::SW_MULTI_DIS_A,
            srmc_pkg::SW_MULTI_DIS_B:
            begin
                m[srmc_pkg::MD_MULTI] = 1'b1; // RULE11
                m[srmc_pkg::MD_DIS]   = 1'b1; // RULE11
            end
            // Reserved codes run as plain single partition, flagged
            default:
                m[srmc_pkg::MD_RSVD] = 1'b1; // RULE8
        endcase
        return m;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    srmc_sync #(
        .WIDTH (srmc_pkg::PIN_W)
    ) u_pin_sync (
        .clk_in (REF_CLK_IN),
        .rst_in (RST_IN),
        .ce_in  (CE_IN),
        .d_in   ({FUNDAMENTAL_RESET_N_IN, HALT_AFTER_RESET_IN, SWITCH_CONFIG_STRAP_IN,
                  REFCLK_FREQ_SELECT_IN, PORT_CLOCKING_SELECT_IN}),
        .q_out  (pins_sync)
    );

    srmc_sync #(
        .WIDTH (1)
    ) u_smb_sync (
        .clk_in (REF_CLK_IN),
        .rst_in (RST_IN),
        .ce_in  (CE_IN),
        .d_in   (MGMT_MASTER_SERIAL_CLOCK_IN),
        .q_out  (smb_clk_s)
    );

    assign {fund_n_s, halt_s, strap_s, fsel_s, clkm_s} = pins_sync;

    assign in_reset    = ~fund_n_s;
    assign release_now = (state == srmc_pkg::S_IN_RESET) && !in_reset;
    assign live_mode   = decode_mode(strap_s);
    assign wr_switch_control_register    = WR_IN && (ADDR_IN == srmc_pkg::REG_SWITCH_CONTROL_REGISTER_ADDR)
                         && (state != srmc_pkg::S_IN_RESET);

    // ------------------------------------------------------------
    // Operating state
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            srmc_pkg::S_IN_RESET:
            begin
                if (!in_reset)
                begin
                    if (live_mode[srmc_pkg::MD_EE_LSB +: 2] != srmc_pkg::EE_NONE)
                        next_state = srmc_pkg::S_EEPROM_INIT; // RULE15
                    else if (halt_latched || halt_s)
                        next_state = srmc_pkg::S_QUASI_RESET; // RULE2
                    else
                        next_state = srmc_pkg::S_NORMAL; // RULE15
                end
            end
            srmc_pkg::S_EEPROM_INIT:
            begin
                if (EEPROM_DONE_IN)
                    next_state = halt_bit ? srmc_pkg::S_QUASI_RESET : srmc_pkg::S_NORMAL;
            end
            srmc_pkg::S_QUASI_RESET:
            begin
                if (!halt_bit)
                    next_state = srmc_pkg::S_NORMAL; // RULE4
            end
            srmc_pkg::S_NORMAL:
                next_state = srmc_pkg::S_NORMAL;
            default:
                next_state = srmc_pkg::S_IN_RESET;
        endcase
        if (in_reset)
            next_state = srmc_pkg::S_IN_RESET; // RULE1
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
            state <= srmc_pkg::S_IN_RESET;
        else if (CE_IN)
            state <= next_state;
    end

    // Registered state flags
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            INTERNAL_RESET_OUT <= 1'b1;
            EEPROM_INIT_OUT    <= 1'b0;
            QUASI_RESET_OUT    <= 1'b0;
            NORMAL_OP_OUT      <= 1'b0;
        end
        else if (CE_IN)
        begin
            INTERNAL_RESET_OUT <= (next_state == srmc_pkg::S_IN_RESET); // RULE1
            EEPROM_INIT_OUT    <= (next_state == srmc_pkg::S_EEPROM_INIT);
            QUASI_RESET_OUT    <= (next_state == srmc_pkg::S_QUASI_RESET); // RULE3
            NORMAL_OP_OUT      <= (next_state == srmc_pkg::S_NORMAL); // RULE3
        end
    end

    // ------------------------------------------------------------
    // Halt request gathered over the whole reset sequence
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
            halt_latched <= 1'b0;
        else if (CE_IN)
        begin
            if (in_reset && (state != srmc_pkg::S_IN_RESET))
                halt_latched <= halt_s;
            else if (in_reset)
                halt_latched <= halt_latched | halt_s; // RULE2
        end
    end

    // Halt bit: set by hardware at release, cleared by software
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
            halt_bit <= 1'b0;
        else if (CE_IN)
        begin
            if (in_reset)
                halt_bit <= 1'b0; // RULE1
            else if (release_now)
                halt_bit <= halt_latched | halt_s; // RULE2
            else if (wr_switch_control_register)
                halt_bit <= WDATA_IN[srmc_pkg::SWITCH_CONTROL_REGISTER_HALT_BIT]; // RULE4
        end
    end

    // ------------------------------------------------------------
    // Strap capture at reset release
    // ------------------------------------------------------------
    // Later strap movement is ignored, so a glitching board cannot
    // change the mode of a running switch
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            strap_cap <= srmc_pkg::SW_SINGLE;
            fsel_cap  <= srmc_pkg::FSEL_100;
            clkm_cap  <= '0;
            mode_cap  <= '0;
        end
        else if (CE_IN && release_now)
        begin
            strap_cap <= strap_s; // RULE14 RULE6
            fsel_cap  <= fsel_s; // RULE14
            clkm_cap  <= clkm_s; // RULE14
            mode_cap  <= live_mode; // RULE14
        end
    end

    assign EEPROM_KIND_OUT     = mode_cap[srmc_pkg::MD_EE_LSB +: 2]; // RULE7
    assign MULTI_PARTITION_OUT = mode_cap[srmc_pkg::MD_MULTI]; // RULE10
    assign REDUCED_LATENCY_OUT = mode_cap[srmc_pkg::MD_LAT]; // RULE9
    assign I2C_RESET_OUT       = mode_cap[srmc_pkg::MD_I2C]; // RULE10
    assign PORTS_DISABLED_OUT  = mode_cap[srmc_pkg::MD_DIS]; // RULE11
    assign STRAP_RESERVED_OUT  = mode_cap[srmc_pkg::MD_RSVD];
    assign REFCLK_MHZ_OUT      = (fsel_cap == srmc_pkg::FSEL_100) ? srmc_pkg::MHZ_100
                                                                   : srmc_pkg::MHZ_125; // RULE5
    assign PORT_CLOCK_MODE_OUT = clkm_cap; // RULE12

    // ------------------------------------------------------------
    // Master serial clock
    // ------------------------------------------------------------
    // Open drain: only the low phase is driven, the pull-up makes
    // the high phase, and a slave holding it low stretches it
    assign smb_active = (state == srmc_pkg::S_EEPROM_INIT)
                        || (IOEXP_ACCESS_IN && (state != srmc_pkg::S_IN_RESET)); // RULE13

    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            smb_cnt <= '0;
            smb_low <= 1'b0;
        end
        else if (CE_IN)
        begin
            if (!smb_active)
            begin
                smb_cnt <= '0;
                smb_low <= 1'b0; // RULE13
            end
            else if (!smb_low && !smb_clk_s)
                smb_cnt <= '0;
            else if (smb_cnt == srmc_pkg::SMB_HALF_CYC - 1'b1)
            begin
                smb_cnt <= '0;
                smb_low <= !smb_low;
            end
            else
                smb_cnt <= smb_cnt + 1'b1;
        end
    end

    assign MGMT_MASTER_SERIAL_CLOCK_OUT    = 1'b0;
    assign MGMT_MASTER_SERIAL_CLOCK_OE_OUT = smb_low; // RULE13

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    always_comb
    begin
        read_mux = '0;
        case (ADDR_IN)
            srmc_pkg::REG_SWITCH_CONTROL_REGISTER_ADDR:
                read_mux[srmc_pkg::SWITCH_CONTROL_REGISTER_HALT_BIT] = halt_bit;
            srmc_pkg::REG_STATUS_ADDR:
            begin
                read_mux[srmc_pkg::ST_STATE_LSB +: 2]                = 2'(state);
                read_mux[srmc_pkg::ST_NORMAL]                        = NORMAL_OP_OUT;
                read_mux[srmc_pkg::ST_QUASI]                         = QUASI_RESET_OUT;
                read_mux[srmc_pkg::ST_STRAP_LSB +: srmc_pkg::STRAP_W] = strap_cap;
                read_mux[srmc_pkg::ST_FSEL]                          = fsel_cap;
                read_mux[srmc_pkg::ST_CLKM_LSB +: srmc_pkg::CLKM_W]   = clkm_cap;
                read_mux[srmc_pkg::ST_MODE_LSB +: srmc_pkg::MD_W]     = mode_cap;
            end
            default:
                read_mux = '0;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
            RDATA_OUT <= '0;
        else if (CE_IN)
            RDATA_OUT <= RD_IN ? read_mux : '0; // RULE3
    end

endmodule

// [verif/srmc_top_monitor.sv]
// Purpose: Port-level checks for the reset and mode control block
// Assumes: Single clock domain, synchronous active-high reset
// Notes:   Bound to srmc_top from the bench top file
`timescale 1ns/1ns
module srmc_top_monitor (
    input wire logic        REF_CLK_IN,
    input wire logic        RST_IN,
    input wire logic        FUNDAMENTAL_RESET_N_IN,
    input wire logic        REFCLK_FREQ_SELECT_IN,
    input wire logic        IOEXP_ACCESS_IN,
    input wire logic [7:0]  ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic        WR_IN,
    input wire logic        RD_IN,
    input wire logic [31:0] RDATA_OUT,
    input wire logic        INTERNAL_RESET_OUT,
    input wire logic        EEPROM_INIT_OUT,
    input wire logic        QUASI_RESET_OUT,
    input wire logic        NORMAL_OP_OUT,
    input wire logic        MGMT_MASTER_SERIAL_CLOCK_OE_OUT,
    input wire logic [7:0]  REFCLK_MHZ_OUT
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);
    a_fund_reset: assert property (!FUNDAMENTAL_RESET_N_IN [*6] |-> INTERNAL_RESET_OUT)
        else $error("fundamental reset not holding logic");
    a_state_onehot: assert property ($onehot({INTERNAL_RESET_OUT, EEPROM_INIT_OUT, QUASI_RESET_OUT, NORMAL_OP_OUT}))
        else $error("state flags not one-hot");
    a_rdata_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 32'h0)
        else $error("read data outside read slot");
    a_freq_decode: assert property (!INTERNAL_RESET_OUT && !$past(INTERNAL_RESET_OUT) |->
        REFCLK_MHZ_OUT == (REFCLK_FREQ_SELECT_IN ? 8'h7D : 8'h64))
        else $error("reference clock decode wrong");
    a_quasi_exit: assert property (QUASI_RESET_OUT && WR_IN && ADDR_IN == 8'h00 && !WDATA_IN[0] &&
        FUNDAMENTAL_RESET_N_IN |-> ##2 NORMAL_OP_OUT && !QUASI_RESET_OUT)
        else $error("halt clear did not start operation");
    a_quasi_hold: assert property (FUNDAMENTAL_RESET_N_IN [*5] ##0 (QUASI_RESET_OUT && !WR_IN
        && !$past(WR_IN)) |=> QUASI_RESET_OUT)
        else $error("quasi-reset left without halt clear");
    a_sclk_idle: assert property (!EEPROM_INIT_OUT && !IOEXP_ACCESS_IN |=> !MGMT_MASTER_SERIAL_CLOCK_OE_OUT)
        else $error("serial clock driven while idle");
    a_sclk_half: assert property ($rose(MGMT_MASTER_SERIAL_CLOCK_OE_OUT) |-> MGMT_MASTER_SERIAL_CLOCK_OE_OUT [*8])
        else $error("serial clock low half too short");
endmodule

// [verif/srmc_far_model.sv]
// Purpose: Serial bus far side: pulled-up clock wire and EEPROM loader
// Assumes: Wire has a board pull-up
// Notes:   Load ends after the first full serial clock cycle
`timescale 1ns/1ns
module srmc_far_model (
    input  wire logic clk_in,
    input  wire logic oe_in,
    input  wire logic loading_in,
    output logic      wire_out,
    output logic      done_out
);
    logic oe_q = 1'b0;
    // Pull-up wins whenever nobody drives low
    assign wire_out = !oe_in;
    initial done_out = 1'b0;
    always @(posedge clk_in)
    begin
        oe_q <= oe_in;
        done_out <= loading_in && oe_q && !oe_in;
    end
endmodule

// [verif/srmc_top_tb.sv]
// Purpose: Self-checking bench for srmc_top
// Assumes: Mode straps change only while fundamental reset is low; port clock select also moves after release
// Notes:   Boots every strap code except reserved 4 to 7, with random halt and clock selects
`timescale 1ns/1ns
module srmc_top_tb;
    logic        clk = 1'b0, rst = 1'b1, fund_n = 1'b0, halt = 1'b0, fsel = 1'b0;
    logic        ioexp = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0]  strap = 4'h0;
    logic [1:0]  csel = 2'h0, ek, pcm;
    logic [7:0]  addr = 8'h00, mhz;
    logic [31:0] wdata = 32'h0, rdata, pw;
    logic        wlev, done, oe, ir, ee, qr, no, mp, rl, i2, pd, rs;
    int          errors = 0, checks_done = 0, seed = 18452, i, n, c_cap, f_cap, k_cap;
    always #2 clk = ~clk;
    assign pw = {11'h0, mhz, pcm, rs, pd, i2, rl, mp, ek, no, qr, ee, ir};
    srmc_top srmc_top_inst (.REF_CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .FUNDAMENTAL_RESET_N_IN(fund_n),
        .HALT_AFTER_RESET_IN(halt), .SWITCH_CONFIG_STRAP_IN(strap), .REFCLK_FREQ_SELECT_IN(fsel),
        .PORT_CLOCKING_SELECT_IN(csel), .MGMT_MASTER_SERIAL_CLOCK_IN(wlev), .MGMT_MASTER_SERIAL_CLOCK_OUT(),
        .MGMT_MASTER_SERIAL_CLOCK_OE_OUT(oe), .EEPROM_DONE_IN(done), .IOEXP_ACCESS_IN(ioexp), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .INTERNAL_RESET_OUT(ir),
        .EEPROM_INIT_OUT(ee), .QUASI_RESET_OUT(qr), .NORMAL_OP_OUT(no), .EEPROM_KIND_OUT(ek),
        .MULTI_PARTITION_OUT(mp), .REDUCED_LATENCY_OUT(rl), .I2C_RESET_OUT(i2), .PORTS_DISABLED_OUT(pd),
        .STRAP_RESERVED_OUT(rs), .REFCLK_MHZ_OUT(mhz), .PORT_CLOCK_MODE_OUT(pcm));
    srmc_far_model srmc_far_model_inst (.clk_in(clk), .oe_in(oe), .loading_in(ee), .wire_out(wlev), .done_out(done));
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Bounded wait for a flag to drop; overrun ends the run
    task automatic wait_low(ref logic sig, input int lim);
        n = 0;
        while (sig !== 1'b0)
        begin
            @(posedge clk);
            #1 n++;
            if (n > lim)
            begin
                errors++;
                give_verdict();
            end
        end
    endtask
    function automatic int mode_of(int c);
        int e;
        e = (c == 1 || c == 9 || c == 12 || c == 13) ? 1 : (c == 2) ? 2 : (c == 3) ? 3 : 0;
        return e | (c >= 10) << 2 | (c == 8 || c == 9) << 3 | (c == 11 || c == 13) << 4 | (c >= 14) << 5
            | (c >= 4 && c <= 7) << 6;
    endfunction
    function automatic logic [31:0] status(int s);
        return 32'(s | (s == 3) << 2 | (s == 2) << 3 | c_cap << 4 | f_cap << 8 | k_cap << 9 | mode_of(c_cap) << 16);
    endfunction
    function automatic logic [31:0] ports_exp(int s);
        return 32'((f_cap ? 125 : 100) << 13 | k_cap << 11 | mode_of(c_cap) << 4 | 1 << s);
    endfunction
    task automatic boot(int c);
        int s, h;
        fund_n <= 1'b0;
        halt <= 1'b0;
        repeat (8) @(posedge clk);
        // Old capture stands through reset
        #1 chk(pw, ports_exp(0));
        c_cap = c;
        f_cap = $random(seed) & 1;
        k_cap = $random(seed) & 3;
        h = $random(seed) & 1;
        strap <= 4'(c);
        fsel <= 1'(f_cap);
        csel <= 2'(k_cap);
        halt <= 1'(h);
        wr_reg(8'h00, 32'h1);
        fund_n <= 1'b1;
        wait_low(ir, 20);
        s = (mode_of(c) & 3) ? 1 : h ? 2 : 3;
        @(posedge clk);
        #1 chk(pw, ports_exp(s));
        // Late strap wiggle must not reach the captured copy
        csel <= 2'($random(seed));
        rd_chk(8'h04, status(s));
        if (s == 1)
        begin
            wait_low(ee, 4000);
            s = h ? 2 : 3;
            rd_chk(8'h04, status(s));
        end
        if (s == 3)
            rd_chk(8'h00, 32'h0);
        if (s == 2)
        begin
            rd_chk(8'h00, 32'h1);
            wr_reg(8'h00, 32'h0);
            rd_chk(8'h04, status(3));
        end
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 32; i++)
            boot(i % 16 | (i & 4) * 2);
        rd_chk(8'h10, 32'h0);
        ioexp <= 1'b1;
        repeat (1300) @(posedge clk);
        #1 chk(32'(oe), 32'h1);
        ioexp <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(32'(oe), 32'h0);
        give_verdict();
    end
endmodule
bind srmc_top srmc_top_monitor srmc_top_monitor_inst (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN),
    .FUNDAMENTAL_RESET_N_IN(FUNDAMENTAL_RESET_N_IN), .REFCLK_FREQ_SELECT_IN(REFCLK_FREQ_SELECT_IN),
    .IOEXP_ACCESS_IN(IOEXP_ACCESS_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .INTERNAL_RESET_OUT(INTERNAL_RESET_OUT), .EEPROM_INIT_OUT(EEPROM_INIT_OUT),
    .QUASI_RESET_OUT(QUASI_RESET_OUT), .NORMAL_OP_OUT(NORMAL_OP_OUT), .REFCLK_MHZ_OUT(REFCLK_MHZ_OUT),
    .MGMT_MASTER_SERIAL_CLOCK_OE_OUT(MGMT_MASTER_SERIAL_CLOCK_OE_OUT));
